//--- mcs_pkg.sv
// Package with offsets, field layout and constants of the modem register bank
`default_nettype none
package mcs_pkg;
   localparam int ADDR_W = 6;
   localparam int DATA_W = 8;
   localparam int TEST_W = 4;
   localparam int RSSI_W = 6;
   localparam int CRC_W = 16;
   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFF_CONFIG_D = 6'h0C;
   localparam logic [ADDR_W-1:0] OFF_FACTORY_TEST = 6'h18;
   localparam logic [ADDR_W-1:0] OFF_STATUS_A = 6'h1C;
   // Modem configuration register D layout
   localparam logic [DATA_W-1:0] CFG_D_RESET = 8'h00;
   localparam logic [DATA_W-1:0] CFG_D_WMASK = 8'h4F;
   localparam int CFG_D_PHASE_RST = 6;
   localparam int CFG_D_TEST_LSB = 0;
   localparam logic [DATA_W-1:0] FACTORY_TEST_RESET = 8'h00;
   localparam logic [DATA_W-1:0] RDATA_IDLE = 8'h00;
   // Modem status register A bit positions
   localparam int ST_TX_READY = 7;
   localparam int ST_ANTENNA_B = 6;
   localparam int ST_CCA = 5;
   localparam int ST_CARRIER = 4;
   localparam int ST_ENERGY = 3;
   localparam int ST_RX_VALID = 2;
   localparam int ST_TX_ACK = 1;
   localparam int ST_CRC_OK = 0;
   // Header checksum
   localparam logic [CRC_W-1:0] CRC_POLY = 16'h1021;
   localparam logic [CRC_W-1:0] CRC_INIT = 16'hFFFF;
   localparam logic [CRC_W-1:0] CRC_RESIDUE = 16'h1D0F;
endpackage : mcs_pkg
`default_nettype wire

//--- mcs_crc16_check.sv
// Serial CRC16 checker run over the received header fields
`default_nettype none
module mcs_crc16_check
   import mcs_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic start_in,
   input wire logic bit_valid_in,
   input wire logic bit_in,
   input wire logic end_in,
   output logic crc_ok_out
);
   logic [CRC_W-1:0] crc_reg;
   logic [CRC_W-1:0] crc_next;
   logic ok_reg;
   logic ok_next;
   logic fb;

   // Shift one header bit per valid strobe, judge residue at the end
   always_comb begin
      fb = crc_reg[CRC_W-1] ^ bit_in;
      crc_next = crc_reg;
      ok_next = ok_reg;
      if (start_in) begin
         crc_next = CRC_INIT; // Preamble never enters the sum
      end else if (bit_valid_in) begin
         crc_next = {crc_reg[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : '0);
      end
      if (end_in && !start_in) begin
         ok_next = (crc_next == CRC_RESIDUE);
      end
   end

   // State registers
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         crc_reg <= CRC_INIT;
         ok_reg <= 1'b0;
      end else begin
         crc_reg <= crc_next;
         ok_reg <= ok_next;
      end
   end

   assign crc_ok_out = ok_reg;

   property p_crc_verdict;
      @(posedge clk_in) disable iff (!reset_n_in)
      (end_in && !start_in) |=> crc_ok_out == (crc_reg == CRC_RESIDUE);
   endproperty
   a_crc_verdict: assert property (p_crc_verdict)
      else $error("header checksum verdict wrong");

   property p_crc_start;
      @(posedge clk_in) disable iff (!reset_n_in)
      start_in |=> crc_reg == CRC_INIT;
   endproperty
   a_crc_start: assert property (p_crc_start)
      else $error("checksum not restarted at header start");
endmodule : mcs_crc16_check
`default_nettype wire

//--- mcs_modem_regs.sv
// Modem configuration register D, factory test register and status register A
`default_nettype none
module mcs_modem_regs
   import mcs_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_n_in,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [DATA_W-1:0] reg_wdata_in,
   output logic [DATA_W-1:0] reg_rdata_out,
   // Receiver and transmitter conditions from the modem core
   input wire logic phase_jump_in,
   input wire logic internal_header_in,
   input wire logic tx_header_done_in,
   input wire logic antenna_b_in,
   input wire logic cca_in,
   input wire logic carrier_lock_in,
   input wire logic [RSSI_W-1:0] rssi_in,
   input wire logic [RSSI_W-1:0] energy_threshold_in,
   input wire logic rx_header_good_in,
   input wire logic hdr_start_in,
   input wire logic hdr_bit_valid_in,
   input wire logic hdr_bit_in,
   input wire logic hdr_end_in,
   input wire logic hdr_check_enable_in,
   input wire logic tx_channel_ack_in,
   // Outputs
   output logic rx_phase_reset_out,
   output logic [TEST_W-1:0] test_mode_out,
   output logic tx_ready_out,
   output logic rx_packet_valid_out,
   output logic cca_out,
   output logic carrier_out,
   output logic energy_over_threshold_out,
   output logic header_reject_out
);
   logic [DATA_W-1:0] cfg_reg, cfg_next;
   logic [DATA_W-1:0] ftest_reg, ftest_next;
   logic [DATA_W-1:0] rdata_reg, rdata_next;
   logic [DATA_W-1:0] status;
   logic ack_meta_reg, ack_sync_reg;
   logic phase_rst_reg, phase_rst_next;
   logic tx_ready_reg, tx_ready_next;
   logic rxv_reg, rxv_next;
   logic cca_reg, cca_next;
   logic crs_reg, crs_next;
   logic ed_reg, ed_next;
   logic ant_reg, ant_next;
   logic rej_reg, rej_next;
   logic crc_ok;

   // Header checksum checker, always running
   mcs_crc16_check u_crc (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .start_in(hdr_start_in),
      .bit_valid_in(hdr_bit_valid_in),
      .bit_in(hdr_bit_in),
      .end_in(hdr_end_in),
      .crc_ok_out(crc_ok)
   );

   // Register writes; reserved config bits are masked off
   always_comb begin
      cfg_next = cfg_reg;
      ftest_next = ftest_reg;
      if (reg_wr_in) begin
         if (reg_addr_in == OFF_CONFIG_D) begin
            cfg_next = reg_wdata_in & CFG_D_WMASK;
         end else if (reg_addr_in == OFF_FACTORY_TEST) begin
            ftest_next = reg_wdata_in;
         end
      end
   end

   // Live status image built from the condition, synchroniser and checksum flops
   always_comb begin
      status = '0;
      status[ST_TX_READY] = tx_ready_reg;
      status[ST_ANTENNA_B] = ant_reg;
      status[ST_CCA] = cca_reg;
      status[ST_CARRIER] = crs_reg;
      status[ST_ENERGY] = ed_reg;
      status[ST_RX_VALID] = rxv_reg;
      status[ST_TX_ACK] = ack_sync_reg;
      status[ST_CRC_OK] = crc_ok;
   end

   // Read data, no side effect on any state
   always_comb begin
      rdata_next = rdata_reg;
      if (reg_rd_in) begin
         case (reg_addr_in)
            OFF_CONFIG_D: rdata_next = cfg_reg;
            OFF_FACTORY_TEST: rdata_next = ftest_reg;
            OFF_STATUS_A: rdata_next = status;
            default: rdata_next = RDATA_IDLE;
         endcase
      end
   end

   // Condition outputs
   always_comb begin
      phase_rst_next = phase_jump_in && cfg_reg[CFG_D_PHASE_RST];
      tx_ready_next = internal_header_in && tx_header_done_in;
      rxv_next = rx_header_good_in;
      cca_next = cca_in;
      crs_next = carrier_lock_in;
      ed_next = rssi_in > energy_threshold_in;
      ant_next = antenna_b_in;
      rej_next = hdr_check_enable_in && !crc_ok;
   end

   // Registers
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         cfg_reg <= CFG_D_RESET;
         ftest_reg <= FACTORY_TEST_RESET;
         rdata_reg <= RDATA_IDLE;
         ack_meta_reg <= 1'b0;
         ack_sync_reg <= 1'b0;
         phase_rst_reg <= 1'b0;
         tx_ready_reg <= 1'b0;
         rxv_reg <= 1'b0;
         cca_reg <= 1'b0;
         crs_reg <= 1'b0;
         ed_reg <= 1'b0;
         ant_reg <= 1'b0;
         rej_reg <= 1'b0;
      end else begin
         cfg_reg <= cfg_next;
         ftest_reg <= ftest_next;
         rdata_reg <= rdata_next;
         ack_meta_reg <= tx_channel_ack_in; // Pin synchroniser
         ack_sync_reg <= ack_meta_reg;
         phase_rst_reg <= phase_rst_next;
         tx_ready_reg <= tx_ready_next;
         rxv_reg <= rxv_next;
         cca_reg <= cca_next;
         crs_reg <= crs_next;
         ed_reg <= ed_next;
         ant_reg <= ant_next;
         rej_reg <= rej_next;
      end
   end

   assign reg_rdata_out = rdata_reg;
   assign rx_phase_reset_out = phase_rst_reg;
   assign test_mode_out = cfg_reg[CFG_D_TEST_LSB +: TEST_W];
   assign tx_ready_out = tx_ready_reg;
   assign rx_packet_valid_out = rxv_reg;
   assign cca_out = cca_reg;
   assign carrier_out = crs_reg;
   assign energy_over_threshold_out = ed_reg;
   assign header_reject_out = rej_reg;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);

   sequence s_cfg_write;
      reg_wr_in && reg_addr_in == OFF_CONFIG_D;
   endsequence
   sequence s_status_read;
      reg_rd_in && reg_addr_in == OFF_STATUS_A;
   endsequence
   sequence s_ack_held;
      tx_channel_ack_in [*3];
   endsequence

   property p_phase_reset;
      (phase_jump_in && cfg_reg[CFG_D_PHASE_RST]) |=> rx_phase_reset_out;
   endproperty
   a_phase_reset: assert property (p_phase_reset)
      else $error("phase reset not raised");

   property p_phase_off;
      !cfg_reg[CFG_D_PHASE_RST] |=> !rx_phase_reset_out;
   endproperty
   a_phase_off: assert property (p_phase_off)
      else $error("phase reset raised while disabled");

   property p_test_mode;
      s_cfg_write |=> test_mode_out == $past(reg_wdata_in[TEST_W-1:0]);
   endproperty
   a_test_mode: assert property (p_test_mode)
      else $error("test mode not taken from write");

   property p_reserved_zero;
      s_cfg_write |=> (cfg_reg & ~CFG_D_WMASK) == '0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved config bits stored");

   property p_tx_ready;
      tx_ready_out == $past(internal_header_in && tx_header_done_in);
   endproperty
   a_tx_ready: assert property (p_tx_ready)
      else $error("transmit ready wrong");

   property p_status_read;
      s_status_read |=> reg_rdata_out[ST_TX_READY] == $past(tx_ready_out)
         && reg_rdata_out[ST_RX_VALID] == $past(rx_packet_valid_out)
         && reg_rdata_out[ST_CCA] == $past(cca_out)
         && reg_rdata_out[ST_CARRIER] == $past(carrier_out)
         && reg_rdata_out[ST_ENERGY] == $past(energy_over_threshold_out);
   endproperty
   a_status_read: assert property (p_status_read)
      else $error("status read does not mirror outputs");

   property p_energy;
      (rssi_in > energy_threshold_in) |=> energy_over_threshold_out;
   endproperty
   a_energy: assert property (p_energy)
      else $error("energy detect missed");

   property p_ack_sync;
      s_ack_held |=> ack_sync_reg;
   endproperty
   a_ack_sync: assert property (p_ack_sync)
      else $error("channel acknowledge not mirrored");

   property p_read_quiet;
      (reg_rd_in && !reg_wr_in) |=> $stable(cfg_reg) && $stable(ftest_reg);
   endproperty
   a_read_quiet: assert property (p_read_quiet)
      else $error("read changed register state");

   property p_antenna;
      antenna_b_in ##1 antenna_b_in |-> ant_reg;
   endproperty
   a_antenna: assert property (p_antenna)
      else $error("antenna status wrong");
endmodule : mcs_modem_regs
`default_nettype wire

//--- mcs_mac_model.sv
// Partner MAC model that acknowledges a clear channel on request
`default_nettype none
module mcs_mac_model #(
   parameter int ACK_DELAY = 2
) (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic want_tx_in,
   output logic tx_channel_ack_out
);
   timeunit 1ns;
   timeprecision 1ns;
   int wait_cnt;
   // Acknowledge on the clock after ACK_DELAY counted cycles of held request, to act as a slow controller
   always @(posedge clk_in) begin
      if (!reset_n_in || !want_tx_in) begin
         wait_cnt <= 0;
         tx_channel_ack_out <= 1'b0;
      end else if (wait_cnt < ACK_DELAY) begin
         wait_cnt <= wait_cnt + 1;
      end else begin
         tx_channel_ack_out <= 1'b1;
      end
   end
endmodule : mcs_mac_model
`default_nettype wire

//--- mcs_modem_regs_bench.sv
// Self-checking bench for the modem configuration and status registers
`default_nettype none
module mcs_modem_regs_bench import mcs_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, pj = 1'b0;
   logic ih = 1'b0, done = 1'b0, ant = 1'b0, cca = 1'b0, car = 1'b0;
   logic rxg = 1'b0, hs = 1'b0, hv = 1'b0, hb = 1'b0, he = 1'b0;
   logic hen = 1'b0, want = 1'b0, ack;
   logic [5:0] addr = 6'h00, rssi = 6'h00, thr = 6'h20;
   logic [7:0] wdata = 8'h00, rdata, v;
   logic [3:0] tmode;
   logic prst, txr, rxv, ccao, caro, eno, rej;
   int mismatches = 0;
   int n_tests = 0;

   mcs_mac_model #(.ACK_DELAY(4)) u_mcs_mac_model (.clk_in(clk),
      .reset_n_in(rst_n), .want_tx_in(want), .tx_channel_ack_out(ack));
   mcs_modem_regs u_mcs_modem_regs (.clk_in(clk), .reset_n_in(rst_n),
      .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_wdata_in(wdata), .reg_rdata_out(rdata), .phase_jump_in(pj),
      .internal_header_in(ih), .tx_header_done_in(done),
      .antenna_b_in(ant), .cca_in(cca), .carrier_lock_in(car),
      .rssi_in(rssi), .energy_threshold_in(thr), .rx_header_good_in(rxg),
      .hdr_start_in(hs), .hdr_bit_valid_in(hv), .hdr_bit_in(hb),
      .hdr_end_in(he), .hdr_check_enable_in(hen),
      .tx_channel_ack_in(ack), .rx_phase_reset_out(prst),
      .test_mode_out(tmode), .tx_ready_out(txr),
      .rx_packet_valid_out(rxv), .cca_out(ccao), .carrier_out(caro),
      .energy_over_threshold_out(eno), .header_reject_out(rej));

   // Free-running device clock
   initial begin
      forever #20 clk = ~clk;
   end

   task automatic check8(input string what, input logic [7:0] exp, got);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check8

   task automatic reg_write(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [5:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : reg_read

   // Bench's own serial CRC step, MSB first
   function automatic logic [15:0] crc_step(logic [15:0] c, logic b);
      return {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC_POLY : 16'h0000);
   endfunction : crc_step

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : give_verdict

   // Reset values, unmapped read, ignored status write, factory test write of zero read back
   task automatic test_reset;
      reg_read(OFF_CONFIG_D, v);
      check8("config d", 8'h00, v);
      reg_write(OFF_FACTORY_TEST, 8'h00);
      reg_write(OFF_STATUS_A, 8'hFF);
      reg_read(OFF_FACTORY_TEST, v);
      check8("factory test", 8'h00, v);
      reg_read(6'h3F, v);
      check8("unmapped", 8'h00, v);
      reg_read(OFF_STATUS_A, v);
      check8("status idle", 8'h00, v);
      $display("test reset done");
   endtask : test_reset

   // Every test mode code, reserved bits and the phase reset enable
   task automatic test_config;
      for (int i = 0; i < 16; i++) begin
         reg_write(OFF_CONFIG_D, 8'(i));
         reg_read(OFF_CONFIG_D, v);
         check8("config d", 8'(i), v);
         check8("test mode", 8'(i), {4'h0, tmode});
      end
      // Stray reserved bits are dropped by the register
      reg_write(OFF_CONFIG_D, 8'hB5);
      reg_read(OFF_CONFIG_D, v);
      check8("config d masked", 8'h05, v);
      reg_write(OFF_CONFIG_D, 8'h40);
      pj <= 1'b1;
      repeat (3) @(posedge clk);
      #1 check8("phase reset on", 8'h01, {7'h00, prst});
      reg_write(OFF_CONFIG_D, 8'h00);
      repeat (2) @(posedge clk);
      #1 check8("phase reset off", 8'h00, {7'h00, prst});
      pj <= 1'b0;
      $display("test config done");
   endtask : test_config

   // Status bits follow the live conditions, reading twice changes none
   task automatic test_status;
      logic [7:0] pat [5] = '{8'hAA, 8'h54, 8'hFE, 8'h00, 8'h80};
      logic [7:0] exp;
      logic [7:0] pins;
      for (int k = 0; k < 5; k++) begin
         @(posedge clk);
         ih <= (k != 4);
         done <= pat[k][7];
         ant <= pat[k][6];
         cca <= pat[k][5];
         car <= pat[k][4];
         rssi <= pat[k][3] ? 6'h21 : (k[0] ? 6'h20 : 6'h1F);
         rxg <= pat[k][2];
         want <= pat[k][1];
         exp = pat[k] & ((k == 4) ? 8'h7E : 8'hFE);
         repeat (10) @(posedge clk);
         #1 check8("tx ready pin", {7'h00, exp[7]}, {7'h00, txr});
         pins = {txr, 1'b0, ccao, caro, eno, rxv, 2'b00};
         check8("condition pins", exp & 8'hBC, pins);
         reg_read(OFF_STATUS_A, v);
         check8("status", exp, v);
         reg_read(OFF_STATUS_A, v);
         check8("status again", exp, v);
      end
      $display("test status done");
   endtask : test_status

   // Header with good or bad checksum, checking on and off
   task automatic send_header(input logic [15:0] d, input logic good);
      logic [15:0] c;
      logic [31:0] frame;
      c = CRC_INIT;
      for (int i = 15; i >= 0; i--) begin
         c = crc_step(c, d[i]);
      end
      frame = {d, good ? ~c : c};
      @(posedge clk);
      hs <= 1'b1;
      @(posedge clk);
      hs <= 1'b0;
      for (int i = 31; i >= 0; i--) begin
         hv <= 1'b1;
         hb <= frame[i];
         he <= (i == 0);
         @(posedge clk);
      end
      hv <= 1'b0;
      he <= 1'b0;
   endtask : send_header

   task automatic test_crc;
      for (int e = 0; e < 2; e++) begin
         for (int g = 1; g >= 0; g--) begin
            hen <= e[0];
            send_header(16'hA5C3, g[0]);
            reg_read(OFF_STATUS_A, v);
            check8("crc ok", 8'(g), {7'h00, v[0]});
            check8("reject", 8'(e & ~g & 1), {7'h00, rej});
         end
      end
      $display("test crc done");
   endtask : test_crc

   // Reset in mid-run clears the stored and registered state
   task automatic test_midreset;
      reg_write(OFF_CONFIG_D, 8'h4F);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      #1 check8("pins in reset", 8'h00, {tmode, prst, txr, rej, rxv});
      reg_read(OFF_CONFIG_D, v);
      check8("config after reset", 8'h00, v);
      $display("test midreset done");
   endtask : test_midreset

   // Main sequence
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      test_reset();
      test_config();
      test_status();
      test_crc();
      test_midreset();
      give_verdict();
   end

   // Watchdog against a hang
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      give_verdict();
   end
endmodule : mcs_modem_regs_bench
`default_nettype wire
